// File: rtl/psodl_pkg.sv
/*
 * constants of the port six data latch: register indices, byte addresses,
 * reset values and bus encodings.
 * assumes a 32-bit axi4-lite slave whose address is decoded on its low 16 bits.
 */
package psodl_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int PIN_W = 16;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int NUM_REG = 3;

   // ------------------------------------------------------------
   // register indices (word index, byte address is four times this)
   // ------------------------------------------------------------
   localparam logic [31:0] IDX_DATA = 32'hFFFFF40C;
   localparam logic [31:0] IDX_DATA_HI = 32'hFFFFF40D;
   localparam logic [31:0] IDX_DIR = 32'hFFFFF42C;
   localparam logic [31:0] IDX_DIR_HI = 32'hFFFFF42D;
   localparam logic [31:0] IDX_FUNC = 32'hFFFFF44C;
   localparam logic [31:0] IDX_FUNC_HI = 32'hFFFFF44D;

   // ------------------------------------------------------------
   // byte addresses seen on the bus, slot 0 data, 1 direction, 2 function
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REG] = '{
      {IDX_DATA[13:0], 2'b00}, {IDX_DIR[13:0], 2'b00}, {IDX_FUNC[13:0], 2'b00}};
   localparam logic [ADDR_W-1:0] REG_ADDR_HI [NUM_REG] = '{
      {IDX_DATA_HI[13:0], 2'b00}, {IDX_DIR_HI[13:0], 2'b00},
      {IDX_FUNC_HI[13:0], 2'b00}};
   localparam logic [PIN_W-1:0] REG_RST [NUM_REG] = '{16'h0000, 16'hFFFF, 16'h0000};
   localparam int SLOT_DATA = 0;
   localparam int SLOT_DIR = 1;
   localparam int SLOT_FUNC = 2;

   // ------------------------------------------------------------
   // strobe patterns and responses
   // ------------------------------------------------------------
   localparam logic [1:0] STRB_HALF = 2'h3;
   localparam logic [1:0] STRB_LOW = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: rtl/psodl_pin_sync.sv
/*
 * two-stage synchroniser for the external pin levels, one chain per bit.
 * assumes the pins are asynchronous to aclk; the first stage feeds only the second.
 */
`timescale 1ns/1ps

module psodl_pin_sync #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ------------------------------------------------------------
   // per-bit chains
   // ------------------------------------------------------------
   logic [WIDTH-1:0] stage_one;

   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      // stage one is read by stage two only, to contain metastability
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            stage_one[b] <= 1'b0;
            sync_out[b] <= 1'b0;
         end else begin
            stage_one[b] <= async_in[b];
            sync_out[b] <= stage_one[b];
         end
      end
   end

endmodule // psodl_pin_sync

// File: rtl/psodl_latch_top.sv
/*
 * port six output data latch with pin-level readback, direction and function
 * select, reached over axi4-lite.
 * assumes pins are asynchronous, alternate-function signals share aclk.
 */
// Register access over AXI4-Lite was left to the implementer.
// Functional notes
// RL1: one 16-bit register, write drives, read returns
// RL2: whole register takes full halfword access only
// RL3: high and low byte registers allow byte access
// RL4: whole and low byte share base address
// RL5: output pin level follows its data bit
// RL6: direction bit 0 output, 1 input, reset input
// RL7: function select picks port or alternate function
// RL8: read returns latch or pin, never alters latch
`timescale 1ns/1ps

module psodl_latch_top
   import psodl_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // pins
   input wire logic [PIN_W-1:0] pin_in,
   output logic [PIN_W-1:0] pin_out,
   output logic [PIN_W-1:0] pin_oe,
   // alternate peripheral functions
   input wire logic [PIN_W-1:0] alt_out,
   input wire logic [PIN_W-1:0] alt_oe
);

   // ------------------------------------------------------------
   // storage and held bus requests
   // ------------------------------------------------------------
   logic [PIN_W-1:0] regs [NUM_REG];
   logic [PIN_W-1:0] pin_level;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [PIN_W-1:0] w_data;
   logic [1:0] w_strb;
   logic do_wr;
   logic wr_ok;
   logic next_aw_held;
   logic next_w_held;
   logic next_bvalid;
   logic next_rvalid;
   logic [DATA_W-1:0] rd_word;
   logic rd_ok;
   logic [PIN_W-1:0] readback;

   psodl_pin_sync #(.WIDTH(PIN_W)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(pin_in),
      .sync_out(pin_level)
   );

   // ------------------------------------------------------------
   // write channel handshake
   // ------------------------------------------------------------
   assign do_wr = aw_held && w_held && !bvalid;

   // address and data may arrive in either order, each is held until used
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_bvalid = bvalid;
      if (awvalid && awready) next_aw_held = 1'b1;
      if (wvalid && wready) next_w_held = 1'b1;
      if (do_wr) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
      end else if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
   end

   // held request and ready flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         bvalid <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         bvalid <= next_bvalid;
         // ready drops while a beat waits, so one write at a time
         awready <= !next_aw_held && !next_bvalid;
         wready <= !next_w_held && !next_bvalid;
      end
   end

   // payload capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= 2'h0;
      end else begin
         if (awvalid && awready) aw_addr <= awaddr;
         if (wvalid && wready) begin
            w_data <= wdata[PIN_W-1:0];
            w_strb <= wstrb[1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   // RL2 halfword or low byte
   always_comb begin
      wr_ok = 1'b0;
      for (int i = 0; i < NUM_REG; i++) begin
         if (aw_addr == REG_ADDR[i] && (w_strb == STRB_HALF || w_strb == STRB_LOW)) begin
            wr_ok = 1'b1;
         end else if (aw_addr == REG_ADDR_HI[i] && w_strb[0]) begin
            wr_ok = 1'b1;
         end
      end
   end

   // response code, refused strobes report slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp <= RESP_OKAY;
      end else if (do_wr) begin
         bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // one writer per register slot
   for (genvar g = 0; g < NUM_REG; g++) begin : g_reg
      // RL3 byte lanes
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            regs[g] <= REG_RST[g];
         end else if (do_wr && aw_addr == REG_ADDR[g]) begin
            // RL4 shared base
            if (w_strb == STRB_HALF) begin
               regs[g] <= w_data;
            end else if (w_strb == STRB_LOW) begin
               regs[g][7:0] <= w_data[7:0];
            end
         end else if (do_wr && aw_addr == REG_ADDR_HI[g] && w_strb[0]) begin
            regs[g][15:8] <= w_data[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // RL8 latch or pin
   assign readback = (regs[SLOT_DATA] & ~regs[SLOT_DIR]) | (pin_level & regs[SLOT_DIR]);

   // high-byte address reads return the upper half in the low lane, upper bits zero
   always_comb begin
      rd_word = '0;
      rd_ok = 1'b0;
      for (int i = 0; i < NUM_REG; i++) begin
         if (araddr == REG_ADDR[i]) begin
            rd_ok = 1'b1;
            rd_word = {16'h0000, (i == SLOT_DATA) ? readback : regs[i]};
         end else if (araddr == REG_ADDR_HI[i]) begin
            rd_ok = 1'b1;
            rd_word = {24'h000000, (i == SLOT_DATA) ? readback[15:8] : regs[i][15:8]};
         end
      end
   end

   assign next_rvalid = rvalid ? !rready : (arvalid && arready);

   // RL1 register read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         arready <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else begin
         rvalid <= next_rvalid;
         arready <= !next_rvalid;
         if (arvalid && arready) begin
            rdata <= rd_word;
            rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   // RL5 RL6 RL7 port or alternate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else begin
         pin_out <= (regs[SLOT_FUNC] & alt_out) | (~regs[SLOT_FUNC] & regs[SLOT_DATA]);
         pin_oe <= (regs[SLOT_FUNC] & alt_oe) | (~regs[SLOT_FUNC] & ~regs[SLOT_DIR]);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_half_write;
      do_wr && aw_addr == REG_ADDR[SLOT_DATA] && w_strb == STRB_HALF;
   endsequence

   a_half_write_lands: assert property (s_half_write // RL1
      |=> regs[SLOT_DATA] == $past(w_data) ##0 bvalid)
      else $error("halfword write not stored");
   a_half_refused: assert property ( // RL2
      do_wr && aw_addr == REG_ADDR[SLOT_DATA] && w_strb == 2'h2
      |=> bresp == RESP_SLVERR && $stable(regs[SLOT_DATA]))
      else $error("upper-lane strobe at base not refused");
   a_high_byte_write: assert property ( // RL3
      do_wr && aw_addr == REG_ADDR_HI[SLOT_DATA] && w_strb[0]
      |=> regs[SLOT_DATA] == {$past(w_data[7:0]), $past(regs[SLOT_DATA][7:0])})
      else $error("high byte write wrong");
   a_low_byte_write: assert property ( // RL4
      do_wr && aw_addr == REG_ADDR[SLOT_DATA] && w_strb == STRB_LOW
      |=> regs[SLOT_DATA][15:8] == $past(regs[SLOT_DATA][15:8])
      && regs[SLOT_DATA][7:0] == $past(w_data[7:0]))
      else $error("low byte write wrong");
   // per bit: a port-mode pin follows last cycle's latch, whatever other bits do
   a_pin_level: assert property (1'b1 // RL5
      |=> (~$past(regs[SLOT_FUNC]) & pin_out) ==
      (~$past(regs[SLOT_FUNC]) & $past(regs[SLOT_DATA])))
      else $error("pin level not following data");
   a_dir_enable: assert property ($stable(regs[SLOT_FUNC]) && regs[SLOT_FUNC] == 16'h0000 // RL6
      |=> pin_oe == ~$past(regs[SLOT_DIR]))
      else $error("output enable not following direction");
   // per bit, so a partly switched port is covered too
   a_alt_select: assert property (1'b1 // RL7
      |=> ((pin_oe ^ $past(alt_oe)) & $past(regs[SLOT_FUNC])) == 16'h0000
      && ((pin_out ^ $past(alt_out)) & $past(regs[SLOT_FUNC])) == 16'h0000)
      else $error("alternate function not selected");
   a_read_no_alter: assert property (arvalid && arready && !do_wr // RL8
      |=> $stable(regs[SLOT_DATA]))
      else $error("read altered latch");
   a_read_mux: assert property (arvalid && arready && araddr == REG_ADDR[SLOT_DATA] // RL8
      |=> rvalid && rdata[15:0] == $past(readback))
      else $error("data read mux wrong");
   a_resp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");

endmodule // psodl_latch_top

// File: sim/port_six_output_data_latch_tb.sv
/* bench for the port six data latch: axi4-lite master tasks and result queues.
   assumes psodl_pkg and psodl_latch_top are compiled before this file. */
`timescale 1ns/1ps

module port_six_output_data_latch_tb;
   import psodl_pkg::*;
   // -------------------------------------------
   // signals
   // -------------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   // ready high except in the one stalled write, never lowered and raised in one step
   logic bready = 1'b1, rready = 1'b1;
   logic awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata;
   logic [3:0] wstrb = '0;
   logic [1:0] bresp, rresp;
   logic [PIN_W-1:0] pin_in = '0, alt_out = '0, alt_oe = '0, pin_out, pin_oe, d, p;
   logic [1:0] exp_b [$];
   logic [33:0] exp_r [$];
   int n_mismatch = 0;
   int samples_checked = 0;

   always #5 aclk = ~aclk;

   psodl_latch_top dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .alt_out(alt_out), .alt_oe(alt_oe));

   // -------------------------------------------
   // checking and closing
   // -------------------------------------------
   task automatic test_done();
      $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp(input logic [33:0] got, input logic [33:0] want);
      samples_checked++;
      if (got !== want) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask

   // monitor: each answer is paired with the oldest note
   always @(posedge aclk) begin
      if (bvalid === 1'b1 && bready === 1'b1) begin
         if (exp_b.size() > 0) cmp({32'h0, bresp}, {32'h0, exp_b.pop_front()});
         else n_mismatch++;
      end
      if (rvalid === 1'b1 && rready === 1'b1) begin
         if (exp_r.size() > 0) cmp({rresp, rdata}, exp_r.pop_front());
         else n_mismatch++;
      end
   end

   // -------------------------------------------
   // bus master tasks
   // -------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [15:0] v, input logic [3:0] s,
                     input logic [1:0] e);
      bit done;
      exp_b.push_back(e);
      awaddr <= a;
      wdata <= {16'h0000, v};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      done = 1'b0;
      for (int i = 0; i < 40 && !done; i++) begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         done = (bvalid === 1'b1 && bready === 1'b1);
      end
      if (!done) begin
         n_mismatch++;
         test_done();
      end
   endtask

   task automatic rd(input logic [15:0] a, input logic [33:0] e);
      bit done;
      exp_r.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      done = 1'b0;
      for (int i = 0; i < 40 && !done; i++) begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         done = (rvalid === 1'b1);
      end
      if (!done) begin
         n_mismatch++;
         test_done();
      end
   endtask

   // pin outputs settle one edge after the register; look a cycle later
   task automatic pins(input logic [15:0] eo, input logic [15:0] ee);
      repeat (2) @(posedge aclk);
      #1 cmp({2'b00, pin_oe, pin_out}, {2'b00, ee, eo});
      @(posedge aclk);
   endtask

   // -------------------------------------------
   // scenarios
   // -------------------------------------------
   initial begin
      void'($urandom(33));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      p = 16'($urandom);
      pin_in <= p;
      // wait out the two-flop pin synchroniser
      repeat (4) @(posedge aclk);
      rd(REG_ADDR[SLOT_DIR], {18'h0, REG_RST[SLOT_DIR]});
      rd(REG_ADDR[SLOT_FUNC], {18'h0, 16'h0000});
      rd(REG_ADDR[SLOT_DATA], {18'h0, p});
      pins(16'h0000, 16'h0000);
      $display("test reset values done");
      d = 16'($urandom);
      wr(REG_ADDR[SLOT_DATA], d, 4'hF, RESP_OKAY);
      wr(REG_ADDR[SLOT_DIR], 16'h0000, 4'h3, RESP_OKAY);
      rd(REG_ADDR[SLOT_DATA], {18'h0, d});
      pins(d, 16'hFFFF);
      $display("test halfword done");
      wr(REG_ADDR[SLOT_DATA], 16'h00A5, 4'h1, RESP_OKAY);
      d[7:0] = 8'hA5;
      wr(REG_ADDR_HI[SLOT_DATA], 16'h003C, 4'h1, RESP_OKAY);
      d[15:8] = 8'h3C;
      rd(REG_ADDR_HI[SLOT_DATA], {26'h0, 8'h3C});
      rd(REG_ADDR[SLOT_DATA], {18'h0, d});
      pins(d, 16'hFFFF);
      $display("test byte access done");
      // refused widths leave the latch alone
      wr(REG_ADDR[SLOT_DATA], 16'hFFFF, 4'h2, RESP_SLVERR);
      wr(REG_ADDR_HI[SLOT_DATA], 16'hFFFF, 4'h2, RESP_SLVERR);
      // response held back by bready low for a few cycles
      bready <= 1'b0;
      fork
         wr(16'h0040, 16'hFFFF, 4'h3, RESP_SLVERR);
         begin
            repeat (6) @(posedge aclk);
            bready <= 1'b1;
         end
      join
      rd(16'h0040, {RESP_SLVERR, 32'h0});
      rd(REG_ADDR[SLOT_DATA], {18'h0, d});
      $display("test refused access done");
      p = 16'($urandom);
      pin_in <= p;
      wr(REG_ADDR_HI[SLOT_DIR], 16'h00FF, 4'h1, RESP_OKAY);
      repeat (3) @(posedge aclk);
      rd(REG_ADDR[SLOT_DATA], {18'h0, p[15:8], d[7:0]});
      pins(d, 16'h00FF);
      wr(REG_ADDR[SLOT_DIR], 16'h0000, 4'h3, RESP_OKAY);
      rd(REG_ADDR[SLOT_DATA], {18'h0, d});
      $display("test direction done");
      p = 16'($urandom);
      alt_out <= p;
      alt_oe <= ~p;
      wr(REG_ADDR[SLOT_FUNC], 16'h0F0F, 4'h3, RESP_OKAY);
      pins((d & 16'hF0F0) | (p & 16'h0F0F), 16'hF0F0 | (~p & 16'h0F0F));
      rd(REG_ADDR[SLOT_FUNC], {18'h0, 16'h0F0F});
      $display("test function select done");
      repeat (3) @(posedge aclk);
      // answers still owed count as mismatches
      if (exp_b.size() + exp_r.size() != 0) n_mismatch++;
      test_done();
   end
endmodule // port_six_output_data_latch_tb
